// ### hdl/cpcr_pkg.sv
// Constants, types and the register map of the processor-state register block.
// Assumes a single clock domain and an AXI4-Lite master for software access.
package cpcr_pkg;

  localparam logic [15:0] CPCR_RESET_VEC_LO = 16'h0000;
  localparam logic [15:0] CPCR_RESET_VEC_HI = 16'h0001;
  localparam logic [7:0]  CPCR_FLAGS_RESET  = 8'h02;
  localparam logic [15:0] CPCR_GPR_BASE     = 16'hfee0;
  localparam logic [15:0] CPCR_GPR_LAST     = 16'hfeff;
  localparam logic [15:0] CPCR_SFR_BASE     = 16'hff00;
  localparam int          CPCR_BANKS        = 4;
  localparam int          CPCR_BANK_REGS    = 8;

  // Status word bit positions.
  localparam int CPCR_BIT_CARRY = 0;
  localparam int CPCR_BIT_SVC   = 1;
  localparam int CPCR_BIT_BSL   = 3;
  localparam int CPCR_BIT_HALF  = 4;
  localparam int CPCR_BIT_BSH   = 5;
  localparam int CPCR_BIT_ZERO  = 6;
  localparam int CPCR_BIT_ACC   = 7;
  localparam int CPCR_NIBBLE    = 4;

  // AXI4-Lite byte addresses.
  localparam logic [7:0] CPCR_A_FLAGS = 8'h00;
  localparam logic [7:0] CPCR_A_SP    = 8'h04;
  localparam logic [7:0] CPCR_A_PC    = 8'h08;
  localparam logic [7:0] CPCR_A_GPR   = 8'h40;
  localparam logic [7:0] CPCR_A_GPR_E = 8'hbc;

  localparam logic [1:0] CPCR_RESP_OKAY   = 2'b00;
  localparam logic [1:0] CPCR_RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    CPCR_PC_SEQ  = 3'b000,
    CPCR_PC_HOLD = 3'b001,
    CPCR_PC_JUMP = 3'b010,
    CPCR_PC_LOAD = 3'b011
  } cpcr_pcop_e;

  typedef enum logic [1:0] {
    CPCR_ST_NONE = 2'b00,
    CPCR_ST_PUSH = 2'b01,
    CPCR_ST_POP  = 2'b10
  } cpcr_stop_e;

  // Result flags produced by the ALU for one operation.
  typedef struct packed {
    logic       update;
    logic [7:0] result;
    logic       halfCarry;
    logic       carry;
    logic       carryValid;
  } cpcr_alu_s;

  // One core request per cycle.
  typedef struct packed {
    cpcr_pcop_e  pcOp;
    logic [2:0]  instLen;
    logic [15:0] jumpTarget;
    cpcr_stop_e  stackOp;
    logic        intEntry;
    logic        flagsPop;
    logic [7:0]  popData;
    logic        intOff;
    logic        intOn;
    logic        bankWrite;
    logic [1:0]  bankNum;
    logic        gprWrite;
    logic        gprPair;
    logic [2:0]  gprSel;
    logic [15:0] gprData;
    logic        spLoad;
    logic [15:0] spData;
  } cpcr_req_s;

endpackage : cpcr_pkg

// ### hdl/cpcr_gpr_bank.sv
// General-purpose register storage: four banks of eight bytes.
// Assumes the caller resolves bank and register index; one write port per side.
`timescale 1ns/1ps
module cpcr_gpr_bank
  import cpcr_pkg::*;
#(
  parameter int BANKS = CPCR_BANKS,
  parameter int REGS  = CPCR_BANK_REGS
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        coreWe,
  input  wire logic        corePair,
  input  wire logic [4:0]  coreIdx,
  input  wire logic [15:0] coreData,
  input  wire logic        busWe,
  input  wire logic [4:0]  busIdx,
  input  wire logic [7:0]  busData,
  input  wire logic [4:0]  rdIdx,
  output logic      [7:0]  rdByte,
  output logic      [15:0] rdPair
);

  logic [7:0] mem_reg  [BANKS*REGS];
  logic [7:0] mem_next [BANKS*REGS];
  logic [4:0] evenIdx;

  assign evenIdx = {rdIdx[4:1], 1'b0};

  always_comb begin
    mem_next = mem_reg;
    if (busWe) begin
      mem_next[busIdx] = busData;
    end
    // A pair write fills the even (low) byte and odd (high) byte together. [RL18]
    if (coreWe) begin
      if (corePair) begin
        mem_next[{coreIdx[4:1], 1'b0}] = coreData[7:0];
        mem_next[{coreIdx[4:1], 1'b1}] = coreData[15:8];
      end else begin
        mem_next[coreIdx] = coreData[7:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < BANKS*REGS; i++) begin
        mem_reg[i] <= 8'h00;
      end
    end else begin
      mem_reg <= mem_next;
    end
  end

  assign rdByte = mem_reg[rdIdx];
  assign rdPair = {mem_reg[evenIdx + 5'h01], mem_reg[evenIdx]}; // [RL18]

endmodule : cpcr_gpr_bank

// ### hdl/cpcr_core_regs.sv
// Processor-state registers: instruction counter, status flags, stack pointer, banks.
// Assumes an instruction sequencer drives coreReq and an AXI4-Lite master for software.
//
// How it works
// RL1: The 16-bit instruction counter advances by each fetched instruction's length.
// RL2: Reset loads the counter from the vector bytes at 0000H and 0001H.
// RL3: The vector low byte comes from the even address, high from odd.
// RL4: Branches load the counter with an immediate or a register value.
// RL5: Status word is pushed on interrupt or push, restored by returns and pop. The code loads it into stackPushData only on a push with interrupt entry.
// RL6: Reset sets the status word to 02H.
// RL7: Accept flag clear refuses maskable requests; set defers to level, masks, priorities.
// RL8: Interrupts-off and acknowledgment clear the accept flag; interrupts-on sets it.
// RL9: Zero flag is set for a zero result and cleared otherwise.
// RL10: Two bank select bits choose one of four banks, set by bank switch.
// RL11: Half carry flags a carry out of or borrow into bit 3.
// RL12: With service level clear, low-priority vectored requests are not acknowledged.
// RL13: Carry captures add overflow, subtract underflow, rotate shift-out and bit results.
// RL14: The stack pointer is 16 bits; software keeps it in high-speed RAM.
// RL15: Stack pointer decrements before each save and increments after each restore.
// RL16: Reset leaves the stack pointer undefined; software loads it before use.
// RL17: General registers sit at FEE0H to FEFFH as four banks of eight.
// RL18: Each register is usable as a byte, and pairs as four 16-bit registers.
// RL19: Software must not touch unassigned special-register addresses FF00H to FFFFH.
// RL20: Software must not execute code from internal high-speed RAM.
// RL21: The selected bank decides which eight-byte group register operands address. Core reads take the bus index while s_axi_arvalid is high.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module cpcr_core_regs
  import cpcr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Core side.
  input  wire cpcr_req_s   coreReq,
  input  wire cpcr_alu_s   aluRes,
  input  wire logic [7:0]  vecByte,
  output logic      [15:0] vecAddr,
  output logic             vecBusy,
  output logic      [15:0] instAddr,
  output logic      [7:0]  statusFlags,
  output logic      [15:0] stackAddr,
  output logic      [15:0] stackMemAddr,
  output logic      [7:0]  stackPushData,
  output logic      [2:0]  gprRdSel,
  output logic      [7:0]  gprRdByte,
  output logic      [15:0] gprRdPair,
  output logic      [15:0] gprDataAddr,
  input  wire logic        irqPending,
  input  wire logic        irqMaskable,
  input  wire logic        irqLowPriority,
  input  wire logic        irqMasked,
  output logic             irqAcceptable,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  typedef enum logic [1:0] {
    CPCR_VEC_LO  = 2'b00,
    CPCR_VEC_HI  = 2'b01,
    CPCR_VEC_RUN = 2'b10
  } cpcr_vec_e;

  cpcr_vec_e   vecState_reg, vecState_next;
  logic [7:0]  vecLow_reg, vecLow_next;
  logic [15:0] pc_reg, pc_next;
  logic [7:0]  flags_reg, flags_next;
  logic [15:0] sp_reg, sp_next;
  logic [15:0] spMem_reg, spMem_next;
  logic [7:0]  pushData_reg, pushData_next;

  logic        awHeld_reg, awHeld_next;
  logic        wHeld_reg, wHeld_next;
  logic [7:0]  awAddr_reg, awAddr_next;
  logic [31:0] wData_reg, wData_next;
  logic [3:0]  wStrb_reg, wStrb_next;
  logic        bValid_reg, bValid_next;
  logic [1:0]  bResp_reg, bResp_next;
  logic        rValid_reg, rValid_next;
  logic [31:0] rData_reg, rData_next;
  logic [1:0]  rResp_reg, rResp_next;

  logic        wrFire;
  logic        busGprWe;
  logic [4:0]  busGprIdx;
  logic [7:0]  gprByte;
  logic [15:0] gprPair;

  function automatic logic [1:0] cpcr_bank(input logic [7:0] f);
    cpcr_bank = {f[CPCR_BIT_BSH], f[CPCR_BIT_BSL]};
  endfunction : cpcr_bank

  // Register operands resolve to the selected bank's group. [RL21]
  function automatic logic [4:0] cpcr_gpr_idx(input logic [7:0] f, input logic [2:0] r);
    cpcr_gpr_idx = {cpcr_bank(f), r};
  endfunction : cpcr_gpr_idx

  function automatic logic cpcr_is_gpr(input logic [7:0] a);
    cpcr_is_gpr = (a >= CPCR_A_GPR) && (a <= CPCR_A_GPR_E) && (a[1:0] == 2'b00);
  endfunction : cpcr_is_gpr

  // Bus words count up from the register base as bank*8+reg, in data-address order. [RL17]
  function automatic logic [4:0] cpcr_bus_idx(input logic [7:0] a);
    cpcr_bus_idx = 5'((a - CPCR_A_GPR) >> 2);
  endfunction : cpcr_bus_idx

  // Vector fetch after reset and counter update.
  always_comb begin
    vecState_next = vecState_reg;
    vecLow_next   = vecLow_reg;
    pc_next       = pc_reg;
    case (vecState_reg)
      CPCR_VEC_LO: begin
        vecLow_next   = vecByte; // [RL3]
        vecState_next = CPCR_VEC_HI;
      end
      CPCR_VEC_HI: begin
        pc_next       = {vecByte, vecLow_reg}; // [RL2] [RL3]
        vecState_next = CPCR_VEC_RUN;
      end
      default: begin
        case (coreReq.pcOp)
          CPCR_PC_SEQ:  pc_next = pc_reg + {13'h0000, coreReq.instLen}; // [RL1]
          CPCR_PC_JUMP: pc_next = coreReq.jumpTarget; // [RL4]
          CPCR_PC_LOAD: pc_next = coreReq.jumpTarget; // [RL4]
          default:      pc_next = pc_reg;
        endcase
        if (wrFire && awAddr_reg == CPCR_A_PC && wStrb_reg[1:0] == 2'b11) begin
          pc_next = wData_reg[15:0];
        end
      end
    endcase
  end

  assign vecAddr = (vecState_reg == CPCR_VEC_LO) ? CPCR_RESET_VEC_LO : CPCR_RESET_VEC_HI;
  assign vecBusy = (vecState_reg != CPCR_VEC_RUN);

  // Status word and stack pointer.
  always_comb begin
    flags_next    = flags_reg;
    sp_next       = sp_reg;
    spMem_next    = spMem_reg;
    pushData_next = pushData_reg;
    if (aluRes.update) begin
      flags_next[CPCR_BIT_ZERO] = (aluRes.result == 8'h00); // [RL9]
      flags_next[CPCR_BIT_HALF] = aluRes.halfCarry; // [RL11]
      if (aluRes.carryValid) begin
        flags_next[CPCR_BIT_CARRY] = aluRes.carry; // [RL13]
      end
    end
    if (coreReq.intOn) begin
      flags_next[CPCR_BIT_ACC] = 1'b1; // [RL8]
    end
    if (coreReq.intOff || coreReq.intEntry) begin
      flags_next[CPCR_BIT_ACC] = 1'b0; // [RL8]
    end
    if (coreReq.bankWrite) begin
      flags_next[CPCR_BIT_BSH] = coreReq.bankNum[1]; // [RL10]
      flags_next[CPCR_BIT_BSL] = coreReq.bankNum[0]; // [RL10]
    end
    if (coreReq.flagsPop) begin
      flags_next = coreReq.popData; // [RL5]
    end
    case (coreReq.stackOp)
      CPCR_ST_PUSH: begin
        sp_next    = sp_reg - 16'h0001; // [RL15]
        spMem_next = sp_reg - 16'h0001; // [RL15]
        if (coreReq.intEntry) begin
          pushData_next = flags_reg; // [RL5]
        end
      end
      CPCR_ST_POP: begin
        spMem_next = sp_reg;
        sp_next    = sp_reg + 16'h0001; // [RL15]
      end
      default: begin
      end
    endcase
    if (coreReq.spLoad) begin
      sp_next = coreReq.spData; // [RL14]
    end
    if (wrFire && awAddr_reg == CPCR_A_FLAGS && wStrb_reg[0]) begin
      flags_next = wData_reg[7:0];
    end
    if (wrFire && awAddr_reg == CPCR_A_SP && wStrb_reg[1:0] == 2'b11) begin
      sp_next = wData_reg[15:0]; // [RL14]
    end
  end

  // Acceptance gating for maskable requests. [RL7] [RL12]
  assign irqAcceptable = irqPending && (!irqMaskable ||
                         (flags_reg[CPCR_BIT_ACC] && !irqMasked &&
                          !(irqLowPriority && !flags_reg[CPCR_BIT_SVC])));

  // AXI4-Lite write and read channels.
  assign wrFire   = awHeld_reg && wHeld_reg && !bValid_reg;
  assign busGprWe = wrFire && cpcr_is_gpr(awAddr_reg) && wStrb_reg[0]; // [RL17]
  assign busGprIdx = cpcr_bus_idx(awAddr_reg);

  always_comb begin
    awHeld_next = awHeld_reg;
    wHeld_next  = wHeld_reg;
    awAddr_next = awAddr_reg;
    wData_next  = wData_reg;
    wStrb_next  = wStrb_reg;
    bValid_next = bValid_reg;
    bResp_next  = bResp_reg;
    rValid_next = rValid_reg;
    rData_next  = rData_reg;
    rResp_next  = rResp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    if (wrFire) begin
      awHeld_next = 1'b0;
      wHeld_next  = 1'b0;
      bValid_next = 1'b1;
      bResp_next  = (awAddr_reg == CPCR_A_FLAGS || awAddr_reg == CPCR_A_SP ||
                     awAddr_reg == CPCR_A_PC || cpcr_is_gpr(awAddr_reg)) ?
                    CPCR_RESP_OKAY : CPCR_RESP_SLVERR;
    end
    if (bValid_reg && s_axi_bready) begin
      bValid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rValid_next = 1'b1;
      rResp_next  = CPCR_RESP_OKAY;
      if (s_axi_araddr == CPCR_A_FLAGS) begin
        rData_next = {24'h000000, flags_reg};
      end else if (s_axi_araddr == CPCR_A_SP) begin
        rData_next = {16'h0000, sp_reg};
      end else if (s_axi_araddr == CPCR_A_PC) begin
        rData_next = {16'h0000, pc_reg};
      end else if (cpcr_is_gpr(s_axi_araddr)) begin
        rData_next = {24'h000000, gprByte};
      end else begin
        rData_next = 32'h00000000;
        rResp_next = CPCR_RESP_SLVERR;
      end
    end else if (rValid_reg && s_axi_rready) begin
      rValid_next = 1'b0;
    end
  end

  assign s_axi_awready = !awHeld_reg && !bValid_reg;
  assign s_axi_wready  = !wHeld_reg && !bValid_reg;
  assign s_axi_arready = !rValid_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = bResp_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign s_axi_rdata   = rData_reg;
  assign s_axi_rresp   = rResp_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      vecState_reg <= CPCR_VEC_LO;
      vecLow_reg   <= 8'h00;
      pc_reg       <= 16'h0000;
      flags_reg    <= CPCR_FLAGS_RESET; // [RL6]
      sp_reg       <= 16'h0000; // Software must load it before stack use. [RL16]
      spMem_reg    <= 16'h0000;
      pushData_reg <= 8'h00;
      awHeld_reg   <= 1'b0;
      wHeld_reg    <= 1'b0;
      awAddr_reg   <= 8'h00;
      wData_reg    <= 32'h00000000;
      wStrb_reg    <= 4'h0;
      bValid_reg   <= 1'b0;
      bResp_reg    <= CPCR_RESP_OKAY;
      rValid_reg   <= 1'b0;
      rData_reg    <= 32'h00000000;
      rResp_reg    <= CPCR_RESP_OKAY;
    end else begin
      vecState_reg <= vecState_next;
      vecLow_reg   <= vecLow_next;
      pc_reg       <= pc_next;
      flags_reg    <= flags_next;
      sp_reg       <= sp_next;
      spMem_reg    <= spMem_next;
      pushData_reg <= pushData_next;
      awHeld_reg   <= awHeld_next;
      wHeld_reg    <= wHeld_next;
      awAddr_reg   <= awAddr_next;
      wData_reg    <= wData_next;
      wStrb_reg    <= wStrb_next;
      bValid_reg   <= bValid_next;
      bResp_reg    <= bResp_next;
      rValid_reg   <= rValid_next;
      rData_reg    <= rData_next;
      rResp_reg    <= rResp_next;
    end
  end

  // Bus and core reads share the lookup index; core reads use the selected bank except while s_axi_arvalid is high.
  cpcr_gpr_bank u_gpr (
    .core_clk (core_clk),
    .rst      (rst),
    .coreWe   (coreReq.gprWrite),
    .corePair (coreReq.gprPair),
    .coreIdx  (cpcr_gpr_idx(flags_reg, coreReq.gprSel)), // [RL21]
    .coreData (coreReq.gprData),
    .busWe    (busGprWe),
    .busIdx   (busGprIdx),
    .busData  (wData_reg[7:0]),
    .rdIdx    (s_axi_arvalid ? cpcr_bus_idx(s_axi_araddr) :
               cpcr_gpr_idx(flags_reg, coreReq.gprSel)),
    .rdByte   (gprByte),
    .rdPair   (gprPair)
  );

  assign instAddr      = pc_reg;
  assign statusFlags   = flags_reg;
  assign stackAddr     = sp_reg;
  assign stackMemAddr  = spMem_reg;
  assign stackPushData = pushData_reg;
  assign gprRdSel      = coreReq.gprSel;
  assign gprRdByte     = gprByte;
  assign gprRdPair     = gprPair;
  assign gprDataAddr   = CPCR_GPR_BASE + {11'h000, cpcr_gpr_idx(flags_reg, coreReq.gprSel)}; // [RL17]

endmodule : cpcr_core_regs

// ### tb/cpcr_core_regs_monitor.sv
// Checker for the processor-state register block, bound to its top module.
// Assumes the single core_clk domain and a synchronous active-high reset.
`timescale 1ns/1ps
module cpcr_core_regs_monitor
  import cpcr_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire cpcr_req_s   coreReq,
  input wire cpcr_alu_s   aluRes,
  input wire logic        vecBusy,
  input wire logic [15:0] instAddr,
  input wire logic [7:0]  statusFlags,
  input wire logic [15:0] stackAddr,
  input wire logic [15:0] stackMemAddr,
  input wire logic        irqPending,
  input wire logic        irqMaskable,
  input wire logic        irqAcceptable,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_flags_reset: assert property ($fell(rst) |-> statusFlags == CPCR_FLAGS_RESET)
    else $error("status word not at reset value");
  // The vector load owns the counter, so both sides of the busy pulse are excluded.
  a_pc_seq: assert property (!vecBusy && !$past(vecBusy) && coreReq.pcOp == CPCR_PC_SEQ
    |=> instAddr - $past(instAddr) == $past(coreReq.instLen))
    else $error("counter did not advance by instruction length");
  a_pc_jump: assert property (!vecBusy && coreReq.pcOp inside {CPCR_PC_JUMP, CPCR_PC_LOAD}
    |=> instAddr == $past(coreReq.jumpTarget))
    else $error("branch target not loaded");
  a_zero_flag: assert property (aluRes.update && !coreReq.flagsPop
    |=> statusFlags[CPCR_BIT_ZERO] == ($past(aluRes.result) == 8'h00))
    else $error("zero flag wrong");
  a_half_flag: assert property (aluRes.update && !coreReq.flagsPop
    |=> statusFlags[CPCR_BIT_HALF] == $past(aluRes.halfCarry))
    else $error("half carry flag wrong");
  a_accept_off: assert property (!coreReq.flagsPop && (coreReq.intEntry
    || coreReq.intOff && !coreReq.intOn) |=> !statusFlags[CPCR_BIT_ACC])
    else $error("accept flag not cleared");
  a_accept_on: assert property (coreReq.intOn && !coreReq.intOff && !coreReq.intEntry
    && !coreReq.flagsPop |=> statusFlags[CPCR_BIT_ACC])
    else $error("accept flag not set");
  a_bank_sel: assert property (coreReq.bankWrite
    |=> {statusFlags[CPCR_BIT_BSH], statusFlags[CPCR_BIT_BSL]} == $past(coreReq.bankNum))
    else $error("bank select not written");
  a_sp_push: assert property (coreReq.stackOp == CPCR_ST_PUSH && !coreReq.spLoad
    |=> stackAddr == $past(stackAddr) - 16'h0001 && stackMemAddr == stackAddr)
    else $error("stack pointer not decremented before save");
  a_sp_pop: assert property (coreReq.stackOp == CPCR_ST_POP && !coreReq.spLoad
    |=> stackAddr == $past(stackAddr) + 16'h0001 && stackMemAddr == $past(stackAddr))
    else $error("stack pointer not incremented after restore");
  a_irq_gate: assert property (irqPending && irqMaskable && !statusFlags[CPCR_BIT_ACC]
    |-> !irqAcceptable)
    else $error("maskable request accepted while disabled");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : cpcr_core_regs_monitor

bind cpcr_core_regs cpcr_core_regs_monitor cpcr_core_regs_monitor_inst (
  .core_clk, .rst, .coreReq, .aluRes, .vecBusy, .instAddr, .statusFlags, .stackAddr,
  .stackMemAddr, .irqPending, .irqMaskable, .irqAcceptable, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid
);

// ### tb/tb.sv
// Self-checking bench for the processor-state register block.
// Assumes a combinational vector memory, which this bench models, and AXI4-Lite access.
`timescale 1ns/1ps
module tb
  import cpcr_pkg::*;
;
  logic        core_clk, rst, vecBusy, irqAcceptable;
  cpcr_req_s   req;
  cpcr_alu_s   alu;
  logic [7:0]  vecByte, statusFlags, stackPushData, s_axi_awaddr, s_axi_araddr, gprRdByte;
  logic [15:0] vecAddr, instAddr, stackAddr, stackMemAddr, gprDataAddr, gprRdPair;
  logic [2:0]  gprRdSel;
  logic        irqPending, irqMaskable, irqLowPriority, irqMasked;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          failures, compares;

  cpcr_core_regs cpcr_core_regs_inst (
    .core_clk, .rst, .coreReq(req), .aluRes(alu), .vecByte, .vecAddr, .vecBusy, .instAddr,
    .statusFlags, .stackAddr, .stackMemAddr, .stackPushData, .gprRdSel, .gprRdByte,
    .gprRdPair, .gprDataAddr, .irqPending, .irqMaskable, .irqLowPriority, .irqMasked,
    .irqAcceptable, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );

  // Distinct bytes at the two vector addresses expose a swapped assembly.
  assign vecByte = vecAddr[0] ? 8'h12 : 8'h34;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic drive(input cpcr_req_s r, input cpcr_alu_s a);
    @(posedge core_clk);
    req <= r;
    alu <= a;
    @(posedge core_clk);
    req <= '0;
    alu <= '0;
    #1;
  endtask : drive

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (aw || w) begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) aw = 1'b0;
      if (s_axi_wready === 1'b1) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge core_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr

  task automatic t_pc();
    cpcr_req_s r;
    r = '0;
    r.instLen = 3'd3;
    drive(r, '0);
    chk("instAddr", 32'h1237, instAddr);
    r.pcOp = CPCR_PC_JUMP;
    r.jumpTarget = 16'hbeef;
    drive(r, '0);
    chk("instAddr", 32'hbeef, instAddr);
    r.pcOp = CPCR_PC_LOAD;
    r.jumpTarget = 16'h0420;
    drive(r, '0);
    chk("instAddr", 32'h0420, instAddr);
    r.pcOp = CPCR_PC_HOLD;
    drive(r, '0);
    chk("instAddr", 32'h0420, instAddr);
  endtask : t_pc

  task automatic t_bank();
    cpcr_req_s r;
    logic [31:0] d;
    logic [1:0] rs;
    for (int b = 0; b < 4; b++) begin
      r = '0;
      r.bankWrite = 1'b1;
      r.bankNum = 2'(b);
      drive(r, '0);
      chk("bank", 32'(b), {statusFlags[5], statusFlags[3]});
      chk("gprDataAddr", 32'hfee0 + 32'(b * 8), gprDataAddr);
      r = '0;
      r.gprWrite = 1'b1;
      r.gprPair = 1'b1;
      r.gprSel = 3'd2;
      r.gprData = {8'ha0 + 8'(b), 8'h50 + 8'(b)};
      drive(r, '0);
      axr(8'h48 + 8'(b * 32), d, rs);
      chk("gprLow", 32'h50 + 32'(b), d);
      axr(8'h4c + 8'(b * 32), d, rs);
      chk("gprHigh", 32'ha0 + 32'(b), d);
      @(posedge core_clk);
      req.gprSel <= 3'd3;
      @(posedge core_clk);
      #1;
      chk("gprRdSel", 32'h3, gprRdSel);
      chk("gprRdByte", 32'ha0 + 32'(b), gprRdByte);
      chk("gprRdPair", {16'h0000, r.gprData}, gprRdPair);
    end
  endtask : t_bank

  task automatic t_alu();
    cpcr_alu_s a[3] = '{'{1'b1, 8'h00, 1'b1, 1'b1, 1'b1}, '{1'b1, 8'h5a, 1'b0, 1'b0, 1'b1},
                        '{1'b1, 8'h80, 1'b1, 1'b1, 1'b0}};
    logic [2:0] e[3] = '{3'b111, 3'b000, 3'b010};
    for (int i = 0; i < 3; i++) begin
      drive('0, a[i]);
      chk("zhc", e[i], {statusFlags[6], statusFlags[4], statusFlags[0]});
    end
  endtask : t_alu

  // Expected status words follow from bank 3, half carry set and the level bit from reset.
  task automatic t_stack();
    cpcr_req_s r;
    r = '0;
    r.spLoad = 1'b1;
    r.spData = 16'hfee0;
    drive(r, '0);
    chk("stackAddr", 32'hfee0, stackAddr);
    r = '0;
    r.stackOp = CPCR_ST_PUSH;
    drive(r, '0);
    chk("stackAddr", 32'hfedf, stackAddr);
    chk("stackMemAddr", 32'hfedf, stackMemAddr);
    r = '0;
    r.intOn = 1'b1;
    drive(r, '0);
    chk("statusFlags", 32'hba, statusFlags);
    r = '0;
    r.stackOp = CPCR_ST_PUSH;
    r.intEntry = 1'b1;
    drive(r, '0);
    chk("stackPushData", 32'hba, stackPushData);
    chk("statusFlags", 32'h3a, statusFlags);
    r = '0;
    r.stackOp = CPCR_ST_POP;
    r.flagsPop = 1'b1;
    r.popData = 8'hc5;
    drive(r, '0);
    chk("statusFlags", 32'hc5, statusFlags);
    chk("stackMemAddr", 32'hfede, stackMemAddr);
  endtask : t_stack

  task automatic irqc(input logic [3:0] v, input logic e);
    @(posedge core_clk);
    {irqPending, irqMaskable, irqLowPriority, irqMasked} <= v;
    @(posedge core_clk);
    #1;
    chk("irqAcceptable", e, irqAcceptable);
  endtask : irqc

  task automatic t_irq();
    cpcr_req_s r;
    irqc(4'b1100, 1'b1);
    irqc(4'b1110, 1'b0);
    irqc(4'b1101, 1'b0);
    r = '0;
    r.intOff = 1'b1;
    drive(r, '0);
    irqc(4'b1100, 1'b0);
    irqc(4'b1000, 1'b1);
    r = '0;
    r.flagsPop = 1'b1;
    r.popData = 8'h82;
    drive(r, '0);
    irqc(4'b1110, 1'b1);
  endtask : t_irq

  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] rs;
    axw(CPCR_A_SP, 32'h0000fd00, rs);
    chk("bresp", CPCR_RESP_OKAY, rs);
    axr(CPCR_A_SP, d, rs);
    chk("stackAddr", 32'hfd00, d);
    axr(CPCR_A_PC, d, rs);
    chk("instAddr", 32'h0420, d);
    axr(8'h0c, d, rs);
    chk("rresp", CPCR_RESP_SLVERR, rs);
    chk("rdata", 32'h0, d);
    axw(8'hc0, 32'h5a, rs);
    chk("bresp", CPCR_RESP_SLVERR, rs);
  endtask : t_bus

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // A run needs well under a thousand cycles; this cuts a stalled handshake short.
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    req = '0;
    alu = '0;
    {irqPending, irqMaskable, irqLowPriority, irqMasked} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr} = 16'h0000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("vecBusy", 32'h1, vecBusy);
    chk("vecAddr", 32'h0001, vecAddr);
    repeat (2) @(posedge core_clk);
    #1;
    chk("vecBusy", 32'h0, vecBusy);
    chk("instAddr", 32'h1234, instAddr);
    chk("statusFlags", 32'h02, statusFlags);
    t_pc();
    t_bank();
    t_alu();
    t_stack();
    t_irq();
    t_bus();
    tally_and_finish();
  end
endmodule : tb
